// ---- src/pin_cfg_pkg.sv ----
// Package: register map, field layout and pad modes of the remote pin configuration block
package pin_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_PINS = 5;
    localparam logic [7:0] OFS_PAIR_ONE_TWO = 8'h1e;
    localparam logic [7:0] OFS_PIN_THREE = 8'h1f;
    localparam logic [7:0] OFS_PAIR_FIVE_SIX = 8'h20;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Nibble field positions
    localparam int FLD_PAD_ENABLE = 0;
    localparam int FLD_DIRECTION = 1;
    localparam int FLD_REMOTE_CTRL = 2;
    localparam int FLD_LOCAL_VALUE = 3;
    localparam int NIBBLE_W = 4;
    localparam logic [3:0] PIN_THREE_WMASK = 4'hf;
    // Pin indexes in the pin vectors: 0=pin1 1=pin2 2=pin3 3=pin5 4=pin6
    localparam int IDX_ONE = 0;
    localparam int IDX_TWO = 1;
    localparam int IDX_THREE = 2;
    localparam int IDX_FIVE = 3;
    localparam int IDX_SIX = 4;
    localparam int NUM_ALT = 3;

    typedef enum logic [1:0] {
        PAD_FUNC_OUT = 2'b00,
        PAD_GP_OUT = 2'b01,
        PAD_HIGH_Z = 2'b10,
        PAD_GP_IN = 2'b11
    } pad_mode_type;

    typedef struct packed {
        logic local_value;
        logic remote_ctrl;
        logic direction;
        logic pad_enable;
    } pin_cfg_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
        logic [NUM_PINS-1:0] gp_mode;
    } pad_drive_type;
endpackage : pin_cfg_pkg

// ---- src/remote_value_hold.sv ----
// Holds the last pin values received from the link, one flop per pin
`timescale 1ns/100ps
`default_nettype none
module remote_value_hold #(
    parameter int WIDTH = 5
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] link_value,
    input wire logic link_valid,
    output logic [WIDTH-1:0] held_value
);
    typedef struct packed {
        logic [WIDTH-1:0] value;
    } hold_state_type;

    hold_state_type state_q;
    hold_state_type state_d;

    // Elaboration-time guard: a zero-width hold has nothing to store
    if (WIDTH < 1) begin : g_bad_width
        $error("remote_value_hold: WIDTH must be at least one");
    end

    always_comb begin
        state_d = state_q;
        if (link_valid) begin
            state_d.value = link_value;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    assign held_value = state_q.value;
endmodule : remote_value_hold
`default_nettype wire

// ---- src/pad_mode_decode.sv ----
// Per-pin pad decode: mode code, output enable and driven value
`timescale 1ns/100ps
`default_nettype none
module pad_mode_decode
    import pin_cfg_pkg::*;
(
    input wire pin_cfg_pkg::pin_cfg_type cfg,
    input wire logic remote_value,
    output pin_cfg_pkg::pad_mode_type mode,
    output logic oe,
    output logic out,
    output logic gp_mode
);
    always_comb begin
        mode = pad_mode_type'({cfg.direction, cfg.pad_enable});
        oe = 1'b0;
        out = 1'b0;
        gp_mode = 1'b0;
        if (cfg.remote_ctrl) begin
            // Remote control forces output regardless of the mode code
            oe = 1'b1;
            gp_mode = 1'b1;
            out = remote_value;
        end else begin
            // Remote value is not looked at on this branch
            case (mode)
                PAD_FUNC_OUT: begin
                    oe = 1'b1;
                end
                PAD_HIGH_Z: begin
                    oe = 1'b0;
                end
                PAD_GP_OUT: begin
                    oe = 1'b1;
                    gp_mode = 1'b1;
                    out = cfg.local_value;
                end
                PAD_GP_IN: begin
                    gp_mode = 1'b1;
                end
                default: begin
                    oe = 1'b0;
                end
            endcase
        end
    end
endmodule : pad_mode_decode
`default_nettype wire

// ---- src/remote_gpio_pin_config.sv ----
// Top: configuration registers and pad control for pins 1, 2, 3, 5 and 6
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module remote_gpio_pin_config
    import pin_cfg_pkg::*;
#(
    parameter int PINS = 5
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire pin_cfg_pkg::reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    input wire logic second_port_select,
    input wire logic [4:0] link_pin_value,
    input wire logic link_pin_valid,
    input wire logic [4:0] pin_in,
    output pin_cfg_pkg::pad_drive_type primary_pad,
    output pin_cfg_pkg::pad_drive_type alt_pad,
    output logic [4:0] pin_in_value
);
    import pin_cfg_pkg::*;

    // Elaboration-time guard: the register map only serves five pins
    if (PINS != NUM_PINS) begin : g_bad_pins
        $error("remote_gpio_pin_config: PINS must equal five");
    end

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] pair_one_two;
        logic [3:0] pin_three;
        logic [7:0] pair_five_six;
        logic [7:0] rdata;
        pad_drive_type primary;
        pad_drive_type alt;
        logic [4:0] in_value;
    } top_state_type;

    top_state_type state_q;
    top_state_type state_d;

    pin_cfg_type [NUM_PINS-1:0] cfg;
    logic [NUM_PINS-1:0] held_remote;
    logic [NUM_PINS-1:0] dec_oe;
    logic [NUM_PINS-1:0] dec_out;
    logic [NUM_PINS-1:0] dec_gp;
    pad_mode_type [NUM_PINS-1:0] dec_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Field layout of each pin within the stored registers
    assign cfg[IDX_ONE] = pin_cfg_type'(state_q.pair_one_two[3:0]);
    assign cfg[IDX_TWO] = pin_cfg_type'(state_q.pair_one_two[7:4]);
    assign cfg[IDX_THREE] = pin_cfg_type'(state_q.pin_three);
    assign cfg[IDX_FIVE] = pin_cfg_type'(state_q.pair_five_six[3:0]);
    assign cfg[IDX_SIX] = pin_cfg_type'(state_q.pair_five_six[7:4]);

    remote_value_hold #(
        .WIDTH(NUM_PINS)
    ) u_hold (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .link_value(link_pin_value),
        .link_valid(link_pin_valid),
        .held_value(held_remote)
    );

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        pad_mode_decode u_dec (
            .cfg(cfg[i]),
            .remote_value(held_remote[i]),
            .mode(dec_mode[i]),
            .oe(dec_oe[i]),
            .out(dec_out[i]),
            .gp_mode(dec_gp[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        // Register writes; reserved bits of 1Fh are not stored
        if (reg_req.wr) begin
            case (reg_req.addr)
                OFS_PAIR_ONE_TWO: state_d.pair_one_two = reg_req.wdata;
                OFS_PIN_THREE: state_d.pin_three = reg_req.wdata[3:0] & PIN_THREE_WMASK;
                OFS_PAIR_FIVE_SIX: state_d.pair_five_six = reg_req.wdata;
                default: state_d.pair_one_two = state_q.pair_one_two;
            endcase
        end
        // Read data stands only in the cycle after the strobe
        state_d.rdata = 8'h00;
        if (reg_req.rd) begin
            case (reg_req.addr)
                OFS_PAIR_ONE_TWO: state_d.rdata = state_q.pair_one_two;
                OFS_PIN_THREE: state_d.rdata = {4'h0, state_q.pin_three};
                OFS_PAIR_FIVE_SIX: state_d.rdata = state_q.pair_five_six;
                default: state_d.rdata = 8'h00;
            endcase
        end
        // Pads: pins 1-3 go to one port only; pins 5 and 6 always primary
        state_d.primary = '0;
        state_d.alt = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (p < NUM_ALT && second_port_select) begin
                state_d.alt.out[p] = dec_out[p];
                state_d.alt.oe[p] = dec_oe[p];
                state_d.alt.gp_mode[p] = dec_gp[p];
            end else begin
                state_d.primary.out[p] = dec_out[p];
                state_d.primary.oe[p] = dec_oe[p];
                state_d.primary.gp_mode[p] = dec_gp[p];
            end
        end
        // Input sample only in general-purpose input mode
        for (int p = 0; p < NUM_PINS; p++) begin
            state_d.in_value[p] = (dec_mode[p] == PAD_GP_IN && !cfg[p].remote_ctrl) ? pin_in[p] : 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    assign primary_pad = state_q.primary;
    assign alt_pad = state_q.alt;
    assign pin_in_value = state_q.in_value;

    ////////////////////////////////////////////////////////////////////////////
    a_reset_zero_cfg: assert property (@(posedge ref_clk) !resetn |=>
        (state_q.pair_one_two == CFG_RESET && state_q.pin_three == 4'h0 && state_q.pair_five_six == CFG_RESET))
        else $error("config not zero after reset");

    a_write_one_two: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && reg_req.wr && reg_req.addr == OFS_PAIR_ONE_TWO) |=> state_q.pair_one_two == $past(reg_req.wdata))
        else $error("1Eh write not stored");

    a_reserved_read_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && reg_req.rd && reg_req.addr == OFS_PIN_THREE) |=> reg_rdata[7:4] == 4'h0)
        else $error("1Fh reserved bits not zero");

    a_alt_port_steer: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && second_port_select) |=> (primary_pad.oe[2:0] == 3'b000 && alt_pad.oe[2:0] == $past(dec_oe[2:0])))
        else $error("pins 1-3 not steered to alternate port");

    a_local_value_drive: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !second_port_select && !cfg[IDX_FIVE].remote_ctrl && cfg[IDX_FIVE].direction == 1'b0
        && cfg[IDX_FIVE].pad_enable) |=> primary_pad.out[IDX_FIVE] == $past(cfg[IDX_FIVE].local_value))
        else $error("pin 5 local value not driven");

    a_remote_forces_out: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && cfg[IDX_SIX].remote_ctrl) |=> (primary_pad.oe[IDX_SIX] && primary_pad.out[IDX_SIX] == $past(held_remote[IDX_SIX])))
        else $error("remote control did not drive pin 6");

    a_remote_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !cfg[IDX_SIX].remote_ctrl && !cfg[IDX_SIX].pad_enable) |=> primary_pad.out[IDX_SIX] == 1'b0)
        else $error("link value leaked to pin 6");

    a_high_z_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !cfg[IDX_FIVE].remote_ctrl && dec_mode[IDX_FIVE] == PAD_HIGH_Z) |=> !primary_pad.oe[IDX_FIVE])
        else $error("pin 5 drives in high impedance mode");

    a_gp_input_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !cfg[IDX_SIX].remote_ctrl && cfg[IDX_SIX].direction && cfg[IDX_SIX].pad_enable)
        |=> (!primary_pad.oe[IDX_SIX] && primary_pad.gp_mode[IDX_SIX]))
        else $error("pin 6 input mode drives");

    a_remote_update: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && link_pin_valid && cfg[IDX_FIVE].remote_ctrl) ##1 (clk_en && cfg[IDX_FIVE].remote_ctrl)
        |=> primary_pad.out[IDX_FIVE] == $past(link_pin_value[IDX_FIVE], 2))
        else $error("remote value not applied two cycles on");
endmodule : remote_gpio_pin_config
`default_nettype wire

// ---- test/far_pin_source.sv ----
// Far-end model: sends pin values across the link
`timescale 1ns/100ps
`default_nettype none
module far_pin_source (
    input wire logic ref_clk,
    output logic [4:0] link_pin_value,
    output logic link_pin_valid
);
    initial begin
        link_pin_value = 5'h00;
        link_pin_valid = 1'b0;
    end

    // One valid cycle per update; the value is scrambled after it so a late capture shows up
    task automatic send(input logic [4:0] v, input int gap);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        link_pin_value <= v;
        link_pin_valid <= 1'b1;
        @(posedge ref_clk);
        link_pin_valid <= 1'b0;
        link_pin_value <= ~v;
    endtask : send
endmodule : far_pin_source
`default_nettype wire

// ---- test/remote_gpio_pin_config_test.sv ----
// Self-checking bench for the remote pin configuration block
`timescale 1ns/100ps
`default_nettype none
module remote_gpio_pin_config_test;
    import pin_cfg_pkg::*;
    logic ref_clk;
    logic resetn;
    logic clk_en;
    reg_req_type reg_req;
    logic [7:0] reg_rdata;
    logic second_port_select;
    logic [4:0] link_pin_value;
    logic link_pin_valid;
    logic [4:0] pin_in;
    pad_drive_type primary_pad;
    pad_drive_type alt_pad;
    logic [4:0] pin_in_value;
    logic [7:0] rd_val;
    int err_total = 0;
    int total_checks = 0;

    remote_gpio_pin_config #(.PINS(NUM_PINS)) uut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .second_port_select(second_port_select),
        .link_pin_value(link_pin_value),
        .link_pin_valid(link_pin_valid),
        .pin_in(pin_in),
        .primary_pad(primary_pad),
        .alt_pad(alt_pad),
        .pin_in_value(pin_in_value)
    );

    far_pin_source link (
        .ref_clk(ref_clk),
        .link_pin_value(link_pin_value),
        .link_pin_valid(link_pin_valid)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk5

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask : reg_rd

    // Pads follow a write two edges later
    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic set_all(input logic [3:0] n);
        reg_wr(OFS_PAIR_ONE_TWO, {n, n});
        reg_wr(OFS_PIN_THREE, {4'h0, n});
        reg_wr(OFS_PAIR_FIVE_SIX, {n, n});
        settle();
    endtask : set_all

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(20000 * 8);
        err_total++;
        close_out();
    end

    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        reg_req = '0;
        second_port_select = 1'b0;
        pin_in = 5'h15;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        settle();
        chk5(primary_pad.oe, 5'h1f);
        chk5(primary_pad.gp_mode, 5'h00);
        for (int i = 0; i < 3; i++) begin
            reg_rd(8'(OFS_PAIR_ONE_TWO + i));
            chk8(rd_val, CFG_RESET);
        end
        $display("reset test done");
        reg_wr(OFS_PAIR_ONE_TWO, 8'ha5);
        reg_wr(OFS_PIN_THREE, 8'hff);
        reg_wr(OFS_PAIR_FIVE_SIX, 8'h5a);
        reg_wr(8'h21, 8'hff);
        reg_rd(OFS_PAIR_ONE_TWO);
        chk8(rd_val, 8'ha5);
        reg_rd(OFS_PIN_THREE);
        chk8(rd_val, 8'h0f);
        reg_rd(OFS_PAIR_FIVE_SIX);
        chk8(rd_val, 8'h5a);
        reg_rd(8'h21);
        chk8(rd_val, 8'h00);
        $display("register test done");
        // Pins 1, 2, 3 and 6 each get a different code (pin 5 shares code 9 with pin 1) so a swapped nibble shows at the pads
        reg_wr(OFS_PAIR_ONE_TWO, 8'h19);
        reg_wr(OFS_PIN_THREE, 8'h03);
        reg_wr(OFS_PAIR_FIVE_SIX, 8'h29);
        settle();
        chk5(primary_pad.oe, 5'h0b);
        chk5(primary_pad.out & 5'h0b, 5'h09);
        chk5(primary_pad.gp_mode & 5'h0f, 5'h0f);
        chk5(pin_in_value, 5'h04);
        set_all(4'h8);
        chk5(primary_pad.oe, 5'h1f);
        chk5(primary_pad.out, 5'h00);
        $display("pad mode test done");
        set_all(4'h7);
        link.send(5'h0b, 0);
        settle();
        chk5(primary_pad.oe, 5'h1f);
        chk5(primary_pad.out, 5'h0b);
        chk5(pin_in_value, 5'h00);
        link.send(5'h14, 3);
        #1;
        chk5(primary_pad.out, 5'h0b);
        @(posedge ref_clk);
        #1;
        chk5(primary_pad.out, 5'h14);
        set_all(4'h1);
        link.send(5'h1f, 0);
        settle();
        chk5(primary_pad.out, 5'h00);
        $display("remote test done");
        set_all(4'h9);
        @(posedge ref_clk);
        second_port_select <= 1'b1;
        settle();
        chk5(alt_pad.oe, 5'h07);
        chk5(alt_pad.out, 5'h07);
        chk5(primary_pad.oe, 5'h18);
        chk5(primary_pad.out, 5'h18);
        $display("port select test done");
        // A write while the clock enable is low must not land
        @(posedge ref_clk);
        clk_en <= 1'b0;
        reg_wr(OFS_PAIR_ONE_TWO, 8'hff);
        clk_en <= 1'b1;
        reg_rd(OFS_PAIR_ONE_TWO);
        chk8(rd_val, 8'h99);
        $display("clock enable test done");
        close_out();
    end
endmodule : remote_gpio_pin_config_test
`default_nettype wire
